// >>> rtl/fhd_consts.vh
// Constants of the fixed-head disk transfer sequencer: register offsets,
// field positions, reset values, codes and timing figures.
// Assumes inclusion by bare name from the design files under rtl/.
`ifndef FHD_CONSTS_VH
`define FHD_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets on the APB
// ----------------------------------------------------------------
`define FHD_OFF_CTRL    8'h00
`define FHD_OFF_WCNT    8'h04
`define FHD_OFF_CPTR    8'h08
`define FHD_OFF_DWTP    8'h0C
`define FHD_OFF_DSP     8'h10
`define FHD_OFF_ANGPOS  8'h14
`define FHD_OFF_STAT    8'h18
`define FHD_OFF_MASK    8'h1C

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define FHD_CTRL_FUNC_LO 0
`define FHD_CTRL_RATE_LO 2
`define FHD_CTRL_GO      4
`define FHD_CTRL_BUSY    31

// Functions
`define FHD_FN_READ     2'h1
`define FHD_FN_WRITE    2'h2
`define FHD_FN_WCHK     2'h3

// Transfer rates
`define FHD_RATE_HIGH   2'h0
`define FHD_RATE_MED    2'h1
`define FHD_RATE_LOW    2'h2

// ----------------------------------------------------------------
// Status and mask bits
// ----------------------------------------------------------------
`define FHD_ST_DONE     0
`define FHD_ST_NED      1
`define FHD_ST_PAR      2
`define FHD_ST_WCE      3
`define FHD_ST_W        4

// ----------------------------------------------------------------
// Geometry, reset values and timing
// ----------------------------------------------------------------
`define FHD_WORD_W      18
`define FHD_POS_W       11
`define FHD_NUM_DISKS   8
`define FHD_RST_CTRL    5'h00
`define FHD_RST_MASK    4'h0
`define FHD_CLK_MHZ     40
`define FHD_SWITCH_US   200
`define FHD_PER_HIGH_US 16
`define FHD_PER_MED_US  32
`define FHD_PER_LOW_US  64

`endif

// >>> rtl/fhd_parity.v
// Lateral parity generator for one disk word (odd parity).
// Assumes a purely combinational use by the sequencer.
`timescale 1ns/100ps
`default_nettype none

module fhd_parity #(
    parameter W = 18
) (
    input  wire [W-1:0] word,
    output wire         par
);
    // Parity bit makes the total count of ones odd
    assign par = ~(^word);
endmodule // fhd_parity

`default_nettype wire

// >>> rtl/fhd_xfer_seq.v
// Transfer sequencer of a fixed-head disk controller with APB registers.
// Assumes disk timing pins asynchronous to pclk; data channel on pclk.
`timescale 1ns/100ps
`default_nettype none
`include "fhd_consts.vh"

module fhd_xfer_seq #(
    parameter NUM_DISKS  = `FHD_NUM_DISKS,
    parameter SWITCH_CYC = `FHD_SWITCH_US * `FHD_CLK_MHZ
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         irq,
    input  wire        slot_in,
    input  wire        index_in,
    input  wire [7:0]  present_in,
    input  wire [17:0] rd_data_in,
    input  wire        rd_par_in,
    output reg  [17:0] wr_data,
    output reg         wr_par,
    output reg         wr_en,
    output reg  [2:0]  disk_sel,
    output reg  [6:0]  track_sel,
    output reg         dch_req,
    output reg         dch_dir,
    output reg  [17:0] dch_addr,
    output reg  [17:0] dch_wdata,
    input  wire [17:0] dch_rdata,
    input  wire        dch_ack
);
    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_FETCH = 3'h1;
    localparam [2:0] ST_WAIT  = 3'h2;
    localparam [2:0] ST_STORE = 3'h3;
    localparam [2:0] ST_ADV   = 3'h4;
    localparam [13:0] SW_CNT  = SWITCH_CYC[13:0];

    // Rate-adjusted word position from the raw slot number
    function [10:0] adj_pos;
        input [10:0] pos;
        input [1:0]  rate;
        begin
            case (rate)
                `FHD_RATE_MED: adj_pos = {pos[0], pos[10:1]};
                `FHD_RATE_LOW: adj_pos = {pos[1:0], pos[10:2]};
                default:       adj_pos = pos;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    reg [29:0] sy1_r;
    reg [29:0] sy2_r;
    reg        slot_d_r;
    reg        index_d_r;
    wire       slot_s    = sy2_r[0];
    wire       index_s   = sy2_r[1];
    wire [7:0] present_s = sy2_r[9:2];
    wire [17:0] rdat_s   = sy2_r[27:10];
    wire       rpar_s    = sy2_r[28];
    wire       slot_evt  = slot_s & ~slot_d_r;
    wire       index_evt = index_s & ~index_d_r;

    // Two flops on every pin, then edge history on the second
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sy1_r     <= 30'h0;
            sy2_r     <= 30'h0;
            slot_d_r  <= 1'b0;
            index_d_r <= 1'b0;
        end else if (ce) begin
            sy1_r     <= {1'b0, rd_par_in, rd_data_in, present_in, index_in, slot_in};
            sy2_r     <= sy1_r;
            slot_d_r  <= slot_s;
            index_d_r <= index_s;
        end
    end

    // ----------------------------------------------------------------
    // Registers and sequencer state
    // ----------------------------------------------------------------
    reg [10:0] angpos_r;    // angular_position_register
    reg        pos_ok_r;    // Position known for the selected disk
    reg [1:0]  func_r;
    reg [1:0]  rate_r;
    reg [17:0] wcnt_r;      // transfer_word_counter, two's complement
    reg [17:0] cptr_r;      // core_transfer_pointer
    reg [17:0] dwtp_r;      // disk_word_track_pointer
    reg [2:0]  dsp_r;       // disk_select_pointer
    reg [3:0]  stat_r;
    reg [3:0]  mask_r;
    reg [3:0]  ev_r;        // One-cycle status events
    reg [2:0]  st_r;
    reg [13:0] sw_r;        // Head switch settle counter
    reg [17:0] buf_r;

    wire        acc     = psel & penable & pready;
    wire        wr_acc  = acc & pwrite;
    wire        busy    = (st_r != ST_IDLE);
    wire [10:0] adj     = adj_pos(index_evt ? 11'h0 : angpos_r + 11'h1, rate_r); // Arriving slot
    wire [17:0] cnt_inc = wcnt_r + 18'h1;
    wire [18:0] ptr_inc = {1'b0, dwtp_r} + 19'h1;
    wire [2:0]  dsp_inc = dsp_r + 3'h1;
    wire        par_rd;
    wire        par_wr;
    wire        hit;

    fhd_parity #(.W(`FHD_WORD_W)) u_par_rd (
        .word (rdat_s),
        .par  (par_rd)
    );
    fhd_parity #(.W(`FHD_WORD_W)) u_par_wr (
        .word (buf_r),
        .par  (par_wr)
    );

    // Slot match: known position, heads settled, adjusted address equal
    assign hit = slot_evt & pos_ok_r & (sw_r == 14'h0) & (adj == dwtp_r[10:0]);

    // slot counter, 2048 slots wrap at index
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            angpos_r <= 11'h0;
        end else if (ce) begin
            if (index_evt)
                angpos_r <= 11'h0;
            else if (slot_evt)
                angpos_r <= angpos_r + 11'h1;
        end
    end

    // Main sequencer and software-writable registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            func_r    <= 2'h0;
            rate_r    <= 2'h0;
            wcnt_r    <= 18'h0;
            cptr_r    <= 18'h0;
            dwtp_r    <= 18'h0;
            dsp_r     <= 3'h0;
            mask_r    <= `FHD_RST_MASK;
            ev_r      <= 4'h0;
            st_r      <= ST_IDLE;
            sw_r      <= 14'h0;
            buf_r     <= 18'h0;
            pos_ok_r  <= 1'b0;
            wr_data   <= 18'h0;
            wr_par    <= 1'b0;
            wr_en     <= 1'b0;
            dch_req   <= 1'b0;
            dch_dir   <= 1'b0;
            dch_wdata <= 18'h0;
        end else if (ce) begin
            ev_r  <= 4'h0;
            wr_en <= 1'b0;
            if (sw_r != 14'h0)
                sw_r <= sw_r - 14'h1;
            if (index_evt)
                pos_ok_r <= 1'b1;
            if (wr_acc && paddr == `FHD_OFF_MASK)
                mask_r <= pwdata[3:0];
            case (st_r)
                ST_IDLE: begin
                    if (wr_acc) begin
                        case (paddr)
                            `FHD_OFF_WCNT: wcnt_r <= pwdata[17:0];
                            `FHD_OFF_CPTR: cptr_r <= pwdata[17:0];
                            `FHD_OFF_DWTP: dwtp_r <= pwdata[17:0];
                            `FHD_OFF_DSP:  dsp_r  <= pwdata[2:0];
                            default:       ;
                        endcase
                    end
                    if (wr_acc && paddr == `FHD_OFF_CTRL) begin
                        // rate field selects 16, 32 or 64 us words
                        func_r <= pwdata[`FHD_CTRL_FUNC_LO +: 2];
                        rate_r <= pwdata[`FHD_CTRL_RATE_LO +: 2];
                        if (pwdata[`FHD_CTRL_GO]
                                && pwdata[`FHD_CTRL_FUNC_LO +: 2] != 2'h0) begin
                            // start on a missing disk fails
                            if (!present_s[dsp_r] || {1'b0, dsp_r} >= NUM_DISKS) begin
                                ev_r[`FHD_ST_NED] <= 1'b1;
                            end else begin
                                sw_r     <= SW_CNT;
                                // phase must be read from this disk
                                pos_ok_r <= 1'b0;
                                if (pwdata[`FHD_CTRL_FUNC_LO +: 2] == `FHD_FN_READ)
                                    st_r <= ST_WAIT;
                                else
                                    st_r <= ST_FETCH;
                            end
                        end
                    end
                end
                ST_FETCH: begin
                    // Core word for write or write check
                    dch_req <= 1'b1;
                    dch_dir <= 1'b0;
                    if (dch_req && dch_ack) begin
                        dch_req <= 1'b0;
                        buf_r   <= dch_rdata;
                        st_r    <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (hit) begin
                        case (func_r)
                            `FHD_FN_WRITE: begin
                                wr_data <= buf_r;
                                wr_par  <= par_wr;
                                wr_en   <= 1'b1;
                                st_r    <= ST_ADV;
                            end
                            `FHD_FN_WCHK: begin
                                if (rpar_s != par_rd) begin
                                    ev_r[`FHD_ST_PAR] <= 1'b1;
                                    st_r <= ST_IDLE;
                                end else if (rdat_s != buf_r) begin
                                    ev_r[`FHD_ST_WCE] <= 1'b1;
                                    st_r <= ST_IDLE;
                                end else begin
                                    st_r <= ST_ADV;
                                end
                            end
                            default: begin
                                if (rpar_s != par_rd) begin
                                    ev_r[`FHD_ST_PAR] <= 1'b1;
                                    st_r <= ST_IDLE;
                                end else begin
                                    dch_wdata <= rdat_s;
                                    dch_dir   <= 1'b1;
                                    dch_req   <= 1'b1;
                                    st_r      <= ST_STORE;
                                end
                            end
                        endcase
                    end
                end
                ST_STORE: begin
                    if (dch_ack) begin
                        dch_req <= 1'b0;
                        st_r    <= ST_ADV;
                    end
                end
                ST_ADV: begin
                    wcnt_r <= cnt_inc;
                    cptr_r <= cptr_r + 18'h1;
                    dwtp_r <= ptr_inc[17:0];
                    if (cnt_inc == 18'h0) begin
                        ev_r[`FHD_ST_DONE] <= 1'b1;
                        st_r <= ST_IDLE;
                    end else if (ptr_inc[18]) begin
                        // no wrap past the last disk
                        if ({1'b0, dsp_r} >= NUM_DISKS - 1 || !present_s[dsp_inc]) begin
                            ev_r[`FHD_ST_NED] <= 1'b1;
                            st_r <= ST_IDLE;
                        end else begin
                            dsp_r    <= dsp_inc;
                            pos_ok_r <= 1'b0;
                            sw_r     <= SW_CNT;
                            st_r     <= (func_r == `FHD_FN_READ) ? ST_WAIT : ST_FETCH;
                        end
                    end else begin
                        if (ptr_inc[11] != dwtp_r[11])
                            sw_r <= SW_CNT;
                        st_r <= (func_r == `FHD_FN_READ) ? ST_WAIT : ST_FETCH;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // Head selection follows the pointers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disk_sel  <= 3'h0;
            track_sel <= 7'h0;
            dch_addr  <= 18'h0;
        end else if (ce) begin
            disk_sel  <= dsp_r;
            track_sel <= dwtp_r[17:11];
            dch_addr  <= cptr_r;
        end
    end

    // Sticky status, write one to clear, set wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r <= 4'h0;
            irq    <= 1'b0;
        end else if (ce) begin
            if (wr_acc && paddr == `FHD_OFF_STAT)
                stat_r <= (stat_r & ~pwdata[3:0]) | ev_r;
            else
                stat_r <= stat_r | ev_r;
            irq <= |(stat_r & mask_r);
        end
    end

    // APB slave: ready one cycle into the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else if (ce) begin
            if (psel && penable && !pready) begin
                pready  <= 1'b1;
                pslverr <= (paddr > `FHD_OFF_MASK) || (paddr[1:0] != 2'h0);
                case (paddr)
                    `FHD_OFF_CTRL: prdata <= {busy, 25'h0, 2'h0, rate_r, func_r};
                    `FHD_OFF_WCNT: prdata <= {14'h0, wcnt_r};
                    `FHD_OFF_CPTR: prdata <= {14'h0, cptr_r};
                    `FHD_OFF_DWTP: prdata <= {14'h0, dwtp_r};
                    `FHD_OFF_DSP:  prdata <= {29'h0, dsp_r};
                    // raw slot number, never rate adjusted
                    `FHD_OFF_ANGPOS: prdata <= {21'h0, angpos_r};
                    `FHD_OFF_STAT: prdata <= {28'h0, stat_r};
                    `FHD_OFF_MASK: prdata <= {28'h0, mask_r};
                    default:       prdata <= 32'h0;
                endcase
            end else begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end
endmodule // fhd_xfer_seq

`default_nettype wire

// >>> verification/fhd_xfer_seq_props.sv
// Port checker for the disk transfer sequencer.
// Assumes it is bound into fhd_xfer_seq with ce held high.
`timescale 1ns/100ps
`default_nettype none

module fhd_xfer_seq_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic [17:0] wr_data,
    input wire logic        wr_par,
    input wire logic        wr_en,
    input wire logic        dch_req,
    input wire logic        dch_dir,
    input wire logic [17:0] dch_addr,
    input wire logic        dch_ack
);
    // ------
    // Checks
    // ------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_apb_answer; psel && penable && !pready |=> pready; endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("pready late");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
    property p_err_cause; pready |-> pslverr == (paddr > 8'h1C || paddr[1:0] != 2'h0); endproperty
    a_err_cause: assert property (p_err_cause) else $error("pslverr wrong");
    property p_err_zero; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero) else $error("unmapped read not zero");
    property p_pos_width; pready && !pwrite && paddr == 8'h14 |-> prdata[31:11] == 21'h0; endproperty
    a_pos_width: assert property (p_pos_width) else $error("position too wide");
    property p_irq_mask;
        psel && penable && pready && pwrite && paddr == 8'h1C && pwdata[3:0] == 4'h0 |=> ##1 !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq with mask clear");
    property p_wr_par; wr_en |-> wr_par == ~^wr_data; endproperty
    a_wr_par: assert property (p_wr_par) else $error("write parity wrong");
    property p_wr_pulse; wr_en |=> !wr_en; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
    property p_dch_hold;
        dch_req && !dch_ack |=> dch_req && $stable(dch_addr) && $stable(dch_dir);
    endproperty
    a_dch_hold: assert property (p_dch_hold) else $error("channel request moved");
    property p_dch_drop; dch_req && dch_ack |=> !dch_req; endproperty
    a_dch_drop: assert property (p_dch_drop) else $error("channel request stuck");

    c_write: cover property (wr_en);
    c_store: cover property (dch_req && dch_ack && dch_dir);
    c_error: cover property (pready && pslverr);
endmodule // fhd_xfer_seq_props

bind fhd_xfer_seq fhd_xfer_seq_props fhd_xfer_seq_props_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .wr_data(wr_data),
    .wr_par(wr_par), .wr_en(wr_en), .dch_req(dch_req), .dch_dir(dch_dir),
    .dch_addr(dch_addr), .dch_ack(dch_ack));
`default_nettype wire

// >>> verification/fhd_core_model.sv
// Core memory behind the data channel; fetches return a scrambled address.
// Assumes the request is held until acknowledged.
`timescale 1ns/100ps
`default_nettype none

module fhd_core_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [3:0]  lat,
    input  wire logic        dch_req,
    input  wire logic [17:0] dch_addr,
    output logic [17:0]      dch_rdata,
    output logic             dch_ack
);
    logic [3:0] wait_r;

    // Answer after lat cycles; read data toggles when not valid
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dch_ack   <= 1'b0;
            wait_r    <= 4'h0;
            dch_rdata <= 18'h00000;
        end else if (dch_req && dch_ack) begin
            dch_ack   <= 1'b0;
            wait_r    <= 4'h0;
            dch_rdata <= ~dch_rdata;
        end else if (dch_req && wait_r >= lat) begin
            dch_ack   <= 1'b1;
            dch_rdata <= dch_addr ^ 18'h2A5A5;
        end else begin
            wait_r    <= dch_req ? wait_r + 4'h1 : 4'h0;
            dch_rdata <= ~dch_rdata;
        end
    end
endmodule // fhd_core_model
`default_nettype wire

// >>> verification/test_fhd_xfer_seq.sv
// Self-checking bench for the disk transfer sequencer.
// Assumes the core model on the channel; the disk is driven here.
`timescale 1ns/100ps
`default_nettype none

module test_fhd_xfer_seq;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr, present_in;
    logic [31:0] pwdata, prdata, q;
    logic        slot_in, index_in, rd_par_in, bad_par, wr_par, wr_en, e;
    logic [17:0] rd_data_in, wr_data, dch_addr, dch_wdata, dch_rdata;
    logic        dch_req, dch_dir, dch_ack;
    logic [3:0]  lat;
    logic [2:0]  disk_sel;
    logic [6:0]  track_sel;
    logic [18:0] wq[$];
    logic [17:0] sq[$];
    int          error_cnt = 0;
    int          samples_checked = 0;

    fhd_xfer_seq #(.SWITCH_CYC(20)) fhd_xfer_seq_i (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .slot_in(slot_in),
        .index_in(index_in), .present_in(present_in), .rd_data_in(rd_data_in),
        .rd_par_in(rd_par_in), .wr_data(wr_data), .wr_par(wr_par), .wr_en(wr_en),
        .disk_sel(disk_sel), .track_sel(track_sel), .dch_req(dch_req), .dch_dir(dch_dir),
        .dch_addr(dch_addr), .dch_wdata(dch_wdata), .dch_rdata(dch_rdata), .dch_ack(dch_ack));
    fhd_core_model fhd_core_model_i (.pclk(pclk), .presetn(presetn), .lat(lat),
        .dch_req(dch_req), .dch_addr(dch_addr), .dch_rdata(dch_rdata), .dch_ack(dch_ack));

    // ------
    // Helpers
    // ------
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // Collect disk writes and channel stores
    always @(posedge pclk) begin
        if (wr_en === 1'b1) wq.push_back({wr_par, wr_data});
        if (dch_req === 1'b1 && dch_ack === 1'b1 && dch_dir === 1'b1) sq.push_back(dch_wdata);
    end

    function automatic logic [17:0] cd(input logic [17:0] a);
        return a ^ 18'h2A5A5;
    endfunction

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(nm, x, q);
    endtask

    // Disk rotation from the index, slot s carries cd(s)
    task automatic spin(input int n);
        for (int s = 0; s < n; s++) begin
            rd_data_in <= cd({7'h00, s[10:0]});
            rd_par_in  <= ~^cd({7'h00, s[10:0]}) ^ bad_par;
            repeat (4) @(posedge pclk);
            slot_in    <= 1'b1;
            index_in   <= (s == 0);
            repeat (4) @(posedge pclk);
            slot_in    <= 1'b0;
            index_in   <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    endtask

    task automatic rst;
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    task automatic xfer(input logic [31:0] ctl, input logic [17:0] n, input logic [17:0] ca,
                        input logic [17:0] ptr, input logic [2:0] dsk, input int gap);
        wr(8'h04, {14'h0, 18'h0 - n});
        wr(8'h08, {14'h0, ca});
        wr(8'h0C, {14'h0, ptr});
        wr(8'h10, {29'h0, dsk});
        wr(8'h18, 32'hF);
        wq.delete();
        sq.delete();
        wr(8'h00, ctl);
        repeat (gap) @(posedge pclk);
    endtask

    // ------
    // Scenarios
    // ------
    task automatic t_regs;
        rc("ctrl", 8'h00, 32'h0);
        rc("mask", 8'h1C, 32'h0);
        rc("status", 8'h18, 32'h0);
        rc("unmapped", 8'h20, 32'h0);
        chk("slverr", 32'h1, {31'h0, e});
        apb(1'b0, 8'h06, 32'h0);
        chk("slverr misaligned", 32'h1, {31'h0, e});
    endtask

    task automatic t_ads;
        wr(8'h00, 32'h4);
        spin(6);
        rc("position", 8'h14, 32'h5);
    endtask

    task automatic t_write;
        lat <= 4'h4;
        wr(8'h1C, 32'h1);
        xfer(32'h12, 18'd3, 18'h100, 18'h2, 3'h0, 25);
        spin(8);
        chk("words", 32'h3, 32'(wq.size()));
        for (int i = 0; i < 3; i++)
            chk("wdata", {13'h0, ~^cd(18'h100 + i), cd(18'h100 + i)}, {13'h0, wq[i]});
        rc("pointer", 8'h0C, 32'h5);
        rc("core pointer", 8'h08, 32'h103);
        rc("status", 8'h18, 32'h1);
        chk("irq", 32'h1, {31'h0, irq});
        wr(8'h18, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        wr(8'h1C, 32'h0);
        lat <= 4'h0;
    endtask

    task automatic t_rates;
        for (int k = 0; k < 2; k++) begin
            xfer(k ? 32'h19 : 32'h15, 18'd2, 18'h40, k ? 18'h20F : 18'h41E, 3'h0, 25);
            spin(72);
            for (int i = 0; i < 2; i++)
                chk("stored", {14'h0, cd(18'(61 + i * (2 + 2 * k)))}, {14'h0, sq[i]});
        end
    endtask

    task automatic t_wchk;
        for (int k = 0; k < 2; k++) begin
            xfer(32'h13, 18'd2, 18'h10 + 18'(k), 18'h10, 3'h0, 25);
            spin(20);
            apb(1'b0, 8'h18, 32'h0);
            chk("compare", k ? 32'h8 : 32'h1, q & (k ? 32'hE : 32'hF));
        end
    endtask

    task automatic t_faults;
        bad_par <= 1'b1;
        xfer(32'h11, 18'd1, 18'h40, 18'h3, 3'h0, 25);
        spin(6);
        apb(1'b0, 8'h18, 32'h0);
        chk("parity", 32'h4, q & 32'hE);
        bad_par    <= 1'b0;
        present_in <= 8'h07;
        xfer(32'h11, 18'd1, 18'h40, 18'h1800, 3'h3, 25);
        apb(1'b0, 8'h18, 32'h0);
        chk("missing disk", 32'h2, q & 32'hE);
        chk("heads", 32'h1B, {22'h0, track_sel, disk_sel});
        present_in <= 8'hFF;
    endtask

    task automatic t_settle;
        xfer(32'h11, 18'd1, 18'h40, 18'h1, 3'h0, 0);
        spin(3);
        chk("settle", 32'h0, 32'(sq.size()));
        rst();
    endtask

    task automatic give_verdict;
        if (error_cnt == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (30000) @(posedge pclk);
        error_cnt++;
        $display("[FAIL] watchdog expected end seen hang");
        give_verdict();
    end

    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, slot_in, index_in, rd_par_in, bad_par} = 8'h00;
        {paddr, pwdata, rd_data_in, lat} = 62'h0;
        ce         = 1'b1;
        present_in = 8'hFF;
        rst();
        t_regs();
        t_ads();
        t_write();
        t_rates();
        t_wchk();
        t_faults();
        t_settle();
        give_verdict();
    end
endmodule // test_fhd_xfer_seq
`default_nettype wire
